// ==== hdl/memory_map_bank_decode.sv ====
// code bank decode, internal data space, stack and on-chip external ram access
`timescale 1ns/10ps
`default_nettype none
`include "memory_map_cfg.svh"
module memory_map_bank_decode #(
  parameter int FLASH_BANKS = 4,
  parameter int XAW = 13
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_code_req,
  input wire logic i_code_fetch,
  input wire logic [15:0] i_code_addr,
  input wire logic i_data_req,
  input wire memory_map_pkg::op_t i_data_op,
  input wire logic i_data_wr,
  input wire logic [7:0] i_data_addr,
  input wire logic [7:0] i_data_wdata,
  input wire logic [15:0] i_data_pointer_pair,
  input wire logic i_flash_write_route,
  output logic o_code_valid,
  output logic [16:0] o_code_flash_addr,
  output logic o_code_lock,
  output logic o_code_reserved,
  output logic o_prog_wr,
  output logic [16:0] o_prog_addr,
  output logic [7:0] o_prog_wdata,
  output logic o_busy,
  output logic o_data_done,
  output logic [7:0] o_data_rdata
);
  localparam logic [16:0] LOCK_ADDR = 17'(FLASH_BANKS * `BANK_BYTES - 1);

  // ****************************************
  // memories
  // ****************************************
  ram_port_if #(.AW(8), .W(8)) iram ();
  ram_port_if #(.AW(XAW), .W(8)) onchip_external_ram ();
  byte_ram #(.AW(8), .W(8)) u_iram (.i_clk(i_clk), .port(iram.mem)); // [RULE10] [RULE19]
  byte_ram #(.AW(XAW), .W(8)) u_onchip_external_ram (.i_clk(i_clk), .port(onchip_external_ram.mem)); // [RULE20]

  // ****************************************
  // state
  // ****************************************
  memory_map_pkg::state_t st_r, st_nxt;
  memory_map_pkg::op_t op_r, op_nxt, cur_op;
  logic wr_r, wr_nxt, cur_wr;
  logic [7:0] wdata_r, wdata_nxt, cur_wdata;
  logic [7:0] banksel_r, banksel_nxt;
  logic [7:0] sp_r, sp_nxt;
  logic [7:0] status_r, status_nxt;
  logic [7:0] page_r, page_nxt;
  logic exec_bank0_r, exec_bank0_nxt;
  logic [7:0] tgt_r, tgt_nxt;
  logic tgt_sfr_r, tgt_sfr_nxt;
  logic tgt_xm_r, tgt_xm_nxt;
  logic [2:0] bitpos_r, bitpos_nxt;
  logic [7:0] sfr_val_r, sfr_val_nxt;
  logic code_valid_nxt, code_lock_nxt, code_res_nxt;
  logic [16:0] code_addr_nxt;
  logic prog_wr_nxt;
  logic [16:0] prog_addr_nxt;
  logic [7:0] prog_wdata_nxt;
  logic done_nxt;
  logic [7:0] rdata_nxt;
  logic [7:0] iram_addr, iram_wd, ptr, byte_a, sfr_old, sfr_wv, sfr_wa, sel_byte;
  logic iram_we, onchip_external_ram_we, issue, sfr_we;
  logic [XAW-1:0] onchip_external_ram_addr;
  logic [15:0] xaddr;
  logic [1:0] code_bank;
  logic accept;

  assign accept = i_data_req && (st_r == memory_map_pkg::ST_IDLE);
  assign cur_op = (st_r == memory_map_pkg::ST_IDLE) ? i_data_op : op_r;
  assign cur_wr = (st_r == memory_map_pkg::ST_IDLE) ? i_data_wr : wr_r;
  assign cur_wdata = (st_r == memory_map_pkg::ST_IDLE) ? i_data_wdata : wdata_r;
  assign iram.addr = iram_addr;
  assign iram.we = iram_we;
  assign iram.wdata = iram_wd;
  assign onchip_external_ram.addr = onchip_external_ram_addr;
  assign onchip_external_ram.we = onchip_external_ram_we;
  assign onchip_external_ram.wdata = cur_wdata;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [16:0] map_code(input logic [15:0] a, input logic [1:0] bank);
    if (a[`UPPER_BIT]) begin
      map_code = {bank, a[14:0]}; // [RULE2] [RULE22]
    end else begin
      map_code = {2'h0, a[14:0]}; // [RULE1]
    end
  endfunction

  function automatic logic [7:0] sfr_read(input logic [7:0] a);
    case (a)
      `BANKSEL_OFS: sfr_read = banksel_r & 8'h33; // [RULE6]
      `STACK_PTR_OFS: sfr_read = sp_r;
      `STATUS_OFS: sfr_read = status_r;
      `PAGE_OFS: sfr_read = page_r;
      default: sfr_read = 8'h00;
    endcase
  endfunction

  // ****************************************
  // code space decode
  // ****************************************
  always_comb begin
    code_bank = i_code_fetch ? banksel_r[`FETCH_MSB:`FETCH_LSB] // [RULE3]
                             : banksel_r[`CONST_MSB:`CONST_LSB]; // [RULE5]
    code_addr_nxt = map_code(i_code_addr, code_bank);
    code_valid_nxt = i_code_req;
    code_lock_nxt = i_code_req && (code_addr_nxt == LOCK_ADDR); // [RULE8]
    code_res_nxt = i_code_req && ((code_addr_nxt > LOCK_ADDR) // [RULE8]
                   || (32'(code_bank) >= FLASH_BANKS)); // [RULE7]
    exec_bank0_nxt = exec_bank0_r;
    if (i_code_req && i_code_fetch) begin
      exec_bank0_nxt = !i_code_addr[`UPPER_BIT]
                       || (banksel_r[`FETCH_MSB:`FETCH_LSB] == 2'h0);
    end
  end

  // ****************************************
  // data space sequencer
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    wr_nxt = wr_r;
    wdata_nxt = wdata_r;
    sp_nxt = sp_r;
    tgt_nxt = tgt_r;
    tgt_sfr_nxt = tgt_sfr_r;
    tgt_xm_nxt = tgt_xm_r;
    bitpos_nxt = bitpos_r;
    sfr_val_nxt = sfr_val_r;
    prog_wr_nxt = 1'b0;
    prog_addr_nxt = o_prog_addr;
    prog_wdata_nxt = o_prog_wdata;
    done_nxt = 1'b0;
    rdata_nxt = o_data_rdata;
    iram_addr = 8'h00;
    iram_we = 1'b0;
    iram_wd = cur_wdata;
    onchip_external_ram_addr = '0;
    onchip_external_ram_we = 1'b0;
    issue = 1'b0;
    ptr = i_data_addr;
    byte_a = 8'h00;
    sfr_we = 1'b0;
    sfr_wa = 8'h00;
    sfr_wv = cur_wdata;
    sfr_old = 8'h00;
    xaddr = 16'h0000;
    sel_byte = 8'h00;
    case (st_r)
      memory_map_pkg::ST_IDLE: begin
        if (i_data_req) begin
          op_nxt = i_data_op;
          wr_nxt = i_data_wr;
          wdata_nxt = i_data_wdata;
          bitpos_nxt = i_data_addr[2:0];
          if (i_data_op == memory_map_pkg::OP_INDIRECT
              || i_data_op == memory_map_pkg::OP_XMOVE_IDX) begin
            iram_addr = {3'h0, status_r[`REGBANK_MSB:`REGBANK_LSB], 2'h0, i_data_addr[0]}; // [RULE14]
            st_nxt = memory_map_pkg::ST_IDX;
          end else begin
            issue = 1'b1;
          end
        end
      end
      memory_map_pkg::ST_IDX: begin
        issue = 1'b1;
        ptr = iram.rdata;
      end
      memory_map_pkg::ST_WAIT: begin
        sel_byte = tgt_sfr_r ? sfr_val_r : (tgt_xm_r ? onchip_external_ram.rdata : iram.rdata);
        rdata_nxt = sel_byte;
        if (op_r == memory_map_pkg::OP_BIT) begin
          rdata_nxt = {7'h00, sel_byte[bitpos_r]}; // [RULE16]
          if (wr_r && !tgt_sfr_r) begin
            iram_addr = tgt_r;
            iram_we = 1'b1;
            iram_wd = sel_byte;
            iram_wd[bitpos_r] = wdata_r[0];
          end
        end
        done_nxt = 1'b1;
        st_nxt = memory_map_pkg::ST_IDLE;
      end
      default: st_nxt = memory_map_pkg::ST_IDLE;
    endcase
    if (issue) begin
      st_nxt = memory_map_pkg::ST_WAIT;
      tgt_sfr_nxt = 1'b0;
      tgt_xm_nxt = 1'b0;
      case (cur_op)
        memory_map_pkg::OP_DIRECT: begin
          if (ptr[7]) begin
            tgt_sfr_nxt = 1'b1; // [RULE11]
            sfr_val_nxt = sfr_read(ptr);
            sfr_we = cur_wr;
            sfr_wa = ptr;
          end else begin
            iram_addr = ptr; // [RULE10]
            iram_we = cur_wr;
          end
        end
        memory_map_pkg::OP_INDIRECT: begin
          iram_addr = ptr; // [RULE12]
          iram_we = cur_wr;
        end
        memory_map_pkg::OP_REG: begin
          iram_addr = {3'h0, status_r[`REGBANK_MSB:`REGBANK_LSB], ptr[2:0]}; // [RULE13]
          iram_we = cur_wr;
        end
        memory_map_pkg::OP_BIT: begin
          if (ptr[7]) begin
            byte_a = {ptr[7:3], 3'h0};
            sfr_old = sfr_read(byte_a);
            tgt_sfr_nxt = 1'b1;
            sfr_val_nxt = sfr_old;
            sfr_we = cur_wr;
            sfr_wa = byte_a;
            sfr_wv = sfr_old;
            sfr_wv[ptr[2:0]] = cur_wdata[0]; // [RULE16]
          end else begin
            byte_a = `BIT_AREA_BASE + {4'h0, ptr[6:3]}; // [RULE15]
            iram_addr = byte_a;
          end
          tgt_nxt = byte_a;
        end
        memory_map_pkg::OP_PUSH: begin
          iram_addr = sp_r + 8'h01; // [RULE17]
          iram_we = 1'b1;
          sp_nxt = sp_r + 8'h01; // [RULE17] [RULE19]
        end
        memory_map_pkg::OP_POP: begin
          iram_addr = sp_r;
          sp_nxt = sp_r - 8'h01;
        end
        default: begin
          if (cur_op == memory_map_pkg::OP_XMOVE_DP) begin
            xaddr = i_data_pointer_pair; // [RULE20]
          end else begin
            xaddr = {page_r, ptr}; // [RULE21]
          end
          tgt_xm_nxt = 1'b1;
          onchip_external_ram_addr = xaddr[XAW-1:0];
          if (cur_wr && i_flash_write_route) begin
            prog_wr_nxt = 1'b1; // [RULE9]
            prog_addr_nxt = map_code(xaddr, banksel_r[`CONST_MSB:`CONST_LSB]); // [RULE5]
            prog_wdata_nxt = cur_wdata;
          end else begin
            onchip_external_ram_we = cur_wr; // [RULE9]
          end
        end
      endcase
    end
  end

  // ****************************************
  // special function registers
  // ****************************************
  always_comb begin
    banksel_nxt = banksel_r;
    status_nxt = status_r;
    page_nxt = page_r;
    if (sfr_we) begin
      case (sfr_wa)
        `BANKSEL_OFS: begin
          banksel_nxt[`CONST_MSB:`CONST_LSB] = sfr_wv[`CONST_MSB:`CONST_LSB];
          if (exec_bank0_r) begin
            banksel_nxt[`FETCH_MSB:`FETCH_LSB] = sfr_wv[`FETCH_MSB:`FETCH_LSB]; // [RULE4]
          end
        end
        `STATUS_OFS: status_nxt = sfr_wv;
        `PAGE_OFS: page_nxt = sfr_wv;
        default: page_nxt = page_r;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_r <= memory_map_pkg::ST_IDLE;
      op_r <= memory_map_pkg::OP_DIRECT;
      wr_r <= 1'b0;
      wdata_r <= 8'h00;
      banksel_r <= `BANKSEL_RST;
      sp_r <= `STACK_PTR_RST; // [RULE18]
      status_r <= `STATUS_RST;
      page_r <= `PAGE_RST;
      exec_bank0_r <= 1'b1;
      tgt_r <= 8'h00;
      tgt_sfr_r <= 1'b0;
      tgt_xm_r <= 1'b0;
      bitpos_r <= 3'h0;
      sfr_val_r <= 8'h00;
      o_code_valid <= 1'b0;
      o_code_flash_addr <= 17'h00000;
      o_code_lock <= 1'b0;
      o_code_reserved <= 1'b0;
      o_prog_wr <= 1'b0;
      o_prog_addr <= 17'h00000;
      o_prog_wdata <= 8'h00;
      o_busy <= 1'b0;
      o_data_done <= 1'b0;
      o_data_rdata <= 8'h00;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      wr_r <= wr_nxt;
      wdata_r <= wdata_nxt;
      banksel_r <= banksel_nxt;
      sp_r <= (sfr_we && sfr_wa == `STACK_PTR_OFS) ? sfr_wv : sp_nxt;
      status_r <= status_nxt;
      page_r <= page_nxt;
      exec_bank0_r <= exec_bank0_nxt;
      tgt_r <= tgt_nxt;
      tgt_sfr_r <= tgt_sfr_nxt;
      tgt_xm_r <= tgt_xm_nxt;
      bitpos_r <= bitpos_nxt;
      sfr_val_r <= sfr_val_nxt;
      o_code_valid <= code_valid_nxt;
      o_code_flash_addr <= code_addr_nxt;
      o_code_lock <= code_lock_nxt;
      o_code_reserved <= code_res_nxt;
      o_prog_wr <= prog_wr_nxt;
      o_prog_addr <= prog_addr_nxt;
      o_prog_wdata <= prog_wdata_nxt;
      o_busy <= (st_nxt != memory_map_pkg::ST_IDLE);
      o_data_done <= done_nxt;
      o_data_rdata <= rdata_nxt;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  property p_low_bank0;
    i_code_req && !i_code_addr[15] |=> o_code_flash_addr[16:15] == 2'h0;
  endproperty
  a_low_bank0: assert property (p_low_bank0) else $error("low code not bank 0"); // [RULE1]

  property p_fetch_bank;
    i_code_req && i_code_fetch && i_code_addr[15]
      |=> o_code_valid && o_code_flash_addr[16:15] == $past(banksel_r[1:0]);
  endproperty
  a_fetch_bank: assert property (p_fetch_bank) else $error("fetch bank wrong"); // [RULE3]

  property p_const_bank;
    i_code_req && !i_code_fetch && i_code_addr[15]
      |=> o_code_flash_addr == {$past(banksel_r[5:4]), $past(i_code_addr[14:0])};
  endproperty
  a_const_bank: assert property (p_const_bank) else $error("constant bank wrong"); // [RULE5]

  property p_fetch_locked;
    !exec_bank0_r |=> $stable(banksel_r[1:0]);
  endproperty
  a_fetch_locked: assert property (p_fetch_locked) else $error("fetch bank changed"); // [RULE4]

  property p_reserved_zero;
    (banksel_r & 8'hcc) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // [RULE6]

  property p_sp_reset;
    $rose(i_reset_n) |-> sp_r == 8'h07;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("stack pointer reset"); // [RULE18]

  property p_push;
    accept && i_data_op == memory_map_pkg::OP_PUSH
      |-> iram_we && iram_addr == sp_r + 8'h01 ##1 sp_r == $past(sp_r) + 8'h01 ##1 o_data_done;
  endproperty
  a_push: assert property (p_push) else $error("push order wrong"); // [RULE17]

  property p_direct_sfr;
    accept && i_data_op == memory_map_pkg::OP_DIRECT && i_data_addr[7] |-> !iram_we;
  endproperty
  a_direct_sfr: assert property (p_direct_sfr) else $error("direct hit upper ram"); // [RULE11]

  property p_no_route;
    !i_flash_write_route |=> !o_prog_wr;
  endproperty
  a_no_route: assert property (p_no_route) else $error("flash write unrouted"); // [RULE9]

  property p_bit_map;
    accept && i_data_op == memory_map_pkg::OP_BIT && !i_data_addr[7]
      |-> iram_addr == 8'h20 + {4'h0, i_data_addr[6:3]};
  endproperty
  a_bit_map: assert property (p_bit_map) else $error("bit byte wrong"); // [RULE15]
endmodule
`default_nettype wire

// ==== hdl/memory_map_cfg.svh ====
// offsets, reset values and sizes for the memory map and bank decode block
//
// Contract
// (RULE1) code addresses 0x0000-0x7FFF always map to flash bank 0
// (RULE2) code addresses 0x8000-0xFFFF map to a bank chosen by the bank select register
// (RULE3) instruction fetches in the upper half use fetch bank field bits 1:0
// (RULE4) fetch bank field changes only when written by code running from bank 0
// (RULE5) code reads and flash writes in the upper half use constant bank bits 5:4
// (RULE6) reserved bits 7:6 and 3:2 read 00b; software writes 00b
// (RULE7) software on smaller parts never selects unimplemented banks
// (RULE8) highest flash address is the lock byte; addresses above it are reserved
// (RULE9) flash read only by code reads; external moves hit ram unless routed to flash
// (RULE10) 256 bytes internal ram; lower 128 reachable directly and indirectly
// (RULE11) direct accesses above 0x7F go to the special function space
// (RULE12) indirect accesses above 0x7F reach the separate upper 128 ram bytes
// (RULE13) working registers map to one of four 8-byte banks by status bits 4:3
// (RULE14) index registers zero and one of the active bank drive indirect addressing
// (RULE15) bit address maps to byte 0x20 plus address/8, bit position address mod 8
// (RULE16) bit operands give single-bit access, byte operands full-byte access
// (RULE17) push writes at pointer plus one, then increments the pointer
// (RULE18) reset loads stack pointer with 0x07
// (RULE19) stack may sit anywhere in 256 bytes and grow to 256 bytes
// (RULE20) 8192 bytes external ram via data pointer or index plus page register
// (RULE21) 8-bit index external moves take the upper address byte from page register
// (RULE22) upper code addresses form flash address as bank joined with bits 14:0
`ifndef MEMORY_MAP_CFG_SVH
`define MEMORY_MAP_CFG_SVH

`define BANKSEL_OFS 8'h84
`define STACK_PTR_OFS 8'h81
`define STATUS_OFS 8'hd0
`define PAGE_OFS 8'haa
`define BANKSEL_RST 8'h00
`define STACK_PTR_RST 8'h07
`define STATUS_RST 8'h00
`define PAGE_RST 8'h00
`define FETCH_MSB 1
`define FETCH_LSB 0
`define CONST_MSB 5
`define CONST_LSB 4
`define REGBANK_MSB 4
`define REGBANK_LSB 3
`define UPPER_BIT 15
`define BIT_AREA_BASE 8'h20
`define BANK_BYTES 32768
`define IRAM_DEPTH 256
`define ONCHIP_EXTERNAL_RAM_DEPTH 8192

`endif

// ==== hdl/memory_map_pkg.sv ====
// types shared by the memory map and bank decode block
package memory_map_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_IDX = 3'h2,
    ST_WAIT = 3'h4
  } state_t;
  typedef enum logic [2:0] {
    OP_DIRECT = 3'h0,
    OP_INDIRECT = 3'h1,
    OP_REG = 3'h2,
    OP_BIT = 3'h3,
    OP_PUSH = 3'h4,
    OP_POP = 3'h5,
    OP_XMOVE_DP = 3'h6,
    OP_XMOVE_IDX = 3'h7
  } op_t;
endpackage

// ==== hdl/ram_port_if.sv ====
// single-port ram access bundle between decoder and ram
`timescale 1ns/10ps
`default_nettype none
interface ram_port_if #(parameter int AW = 8, parameter int W = 8);
  logic [AW-1:0] addr;
  logic we;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== hdl/byte_ram.sv ====
// single-port ram with registered read data
`timescale 1ns/10ps
`default_nettype none
module byte_ram #(parameter int AW = 8, parameter int W = 8) (
  input wire logic i_clk,
  ram_port_if.mem port
);
  logic [W-1:0] store [0:(1<<AW)-1];
  logic [W-1:0] rdata_r;
  logic [W-1:0] rdata_nxt;

  always_comb begin
    rdata_nxt = store[port.addr];
  end

  always_ff @(posedge i_clk) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
    rdata_r <= rdata_nxt;
  end

  assign port.rdata = rdata_r;
endmodule
`default_nettype wire

// ==== testbench/core_access_model.sv ====
// core-side access model driving the decode block's request ports
`timescale 1ns/10ps
`default_nettype none
module core_access_model (
  input wire logic i_clk,
  input wire logic i_done,
  input wire logic [7:0] i_rdata,
  output logic o_code_req,
  output logic o_code_fetch,
  output logic [15:0] o_code_addr,
  output logic o_data_req,
  output memory_map_pkg::op_t o_data_op,
  output logic o_data_wr,
  output logic [7:0] o_data_addr,
  output logic [7:0] o_data_wdata,
  output logic [15:0] o_dp,
  output logic o_route
);
  // ****************************************
  // idle levels
  // ****************************************
  initial begin
    o_code_req = 1'b0;
    o_code_fetch = 1'b0;
    o_code_addr = 16'h0000;
    o_data_req = 1'b0;
    o_data_op = memory_map_pkg::OP_DIRECT;
    o_data_wr = 1'b0;
    o_data_addr = 8'h00;
    o_data_wdata = 8'h00;
    o_dp = 16'h0000;
    o_route = 1'b0;
  end

  // ****************************************
  // access tasks
  // ****************************************
  task automatic code_access(input logic fetch, input logic [15:0] addr);
    @(posedge i_clk);
    o_code_req <= 1'b1;
    o_code_fetch <= fetch;
    o_code_addr <= addr;
    @(posedge i_clk);
    o_code_req <= 1'b0;
    #1;
  endtask

  task automatic set_route(input logic r);
    @(posedge i_clk);
    o_route <= r;
  endtask

  task automatic data_op(input memory_map_pkg::op_t op, input logic wr, input logic [7:0] addr,
                         input logic [7:0] wdata, input logic [15:0] dp,
                         output logic [7:0] rdata, output logic ok);
    int n;
    @(posedge i_clk);
    o_data_req <= 1'b1;
    o_data_op <= op;
    o_data_wr <= wr;
    o_data_addr <= addr;
    o_dp <= dp;
    // reserved bank select bits written as zero; all four banks exist here
    o_data_wdata <= (op == memory_map_pkg::OP_DIRECT && addr == 8'h84) ? (wdata & 8'h33) : wdata;
    @(posedge i_clk);
    o_data_req <= 1'b0;
    ok = 1'b0;
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge i_clk);
      #1;
      ok = (i_done === 1'b1);
    end
    rdata = i_rdata;
  endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the memory map and bank decode block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam memory_map_pkg::op_t K_DIR = memory_map_pkg::OP_DIRECT;
  localparam memory_map_pkg::op_t K_IND = memory_map_pkg::OP_INDIRECT;
  localparam memory_map_pkg::op_t K_REG = memory_map_pkg::OP_REG;
  localparam memory_map_pkg::op_t K_BIT = memory_map_pkg::OP_BIT;
  localparam memory_map_pkg::op_t K_PUSH = memory_map_pkg::OP_PUSH;
  localparam memory_map_pkg::op_t K_POP = memory_map_pkg::OP_POP;
  localparam memory_map_pkg::op_t K_XDP = memory_map_pkg::OP_XMOVE_DP;
  localparam memory_map_pkg::op_t K_XIX = memory_map_pkg::OP_XMOVE_IDX;
  logic i_clk;
  logic i_reset_n;
  logic code_req, code_fetch, data_req, data_wr, route;
  logic [15:0] code_addr, dp;
  memory_map_pkg::op_t data_op;
  logic [7:0] data_addr, data_wdata, data_rdata, prog_wdata, rv;
  logic code_valid, code_lock, code_reserved, prog_wr, busy, data_done, ok;
  logic [16:0] code_flash_addr, prog_addr;
  int num_errors, samples_checked, cycles, prog_count, busy_count, busy_mark;

  // ****************************************
  // instances
  // ****************************************
  memory_map_bank_decode #(.FLASH_BANKS(4), .XAW(13)) i_memory_map_bank_decode (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_code_req(code_req), .i_code_fetch(code_fetch),
    .i_code_addr(code_addr), .i_data_req(data_req), .i_data_op(data_op), .i_data_wr(data_wr),
    .i_data_addr(data_addr), .i_data_wdata(data_wdata), .i_data_pointer_pair(dp),
    .i_flash_write_route(route), .o_code_valid(code_valid), .o_code_flash_addr(code_flash_addr),
    .o_code_lock(code_lock), .o_code_reserved(code_reserved), .o_prog_wr(prog_wr),
    .o_prog_addr(prog_addr), .o_prog_wdata(prog_wdata), .o_busy(busy),
    .o_data_done(data_done), .o_data_rdata(data_rdata));
  core_access_model i_core_access_model (
    .i_clk(i_clk), .i_done(data_done), .i_rdata(data_rdata), .o_code_req(code_req),
    .o_code_fetch(code_fetch), .o_code_addr(code_addr), .o_data_req(data_req),
    .o_data_op(data_op), .o_data_wr(data_wr), .o_data_addr(data_addr),
    .o_data_wdata(data_wdata), .o_dp(dp), .o_route(route));

  // ****************************************
  // clock, timeout, program write count
  // ****************************************
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (prog_wr === 1'b1) prog_count++;
    if (busy === 1'b1) busy_count++;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic op(input memory_map_pkg::op_t k, input logic w, input logic [7:0] a,
                    input logic [7:0] d, input logic [15:0] p);
    i_core_access_model.data_op(k, w, a, d, p, rv, ok);
    check(17'(ok), 17'h1);
  endtask
  task automatic code_chk(input logic f, input logic [15:0] a, input logic [16:0] exp,
                          input logic lk);
    i_core_access_model.code_access(f, a);
    check(17'(code_valid), 17'h1);
    check(code_flash_addr, exp);
    check(17'(code_lock), 17'(lk));
    check(17'(code_reserved), 17'h0);
  endtask
  task automatic stop_test();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    num_errors = 0;
    samples_checked = 0;
    cycles = 0;
    prog_count = 0;
    busy_count = 0;
    busy_mark = 0;
    i_reset_n = 1'b0;
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    op(K_DIR, 1'b0, 8'h81, 8'h00, 16'h0);
    check(17'(rv), 17'h07);
    op(K_DIR, 1'b0, 8'h84, 8'h00, 16'h0);
    check(17'(rv), 17'h00);
    for (int b = 0; b < 4; b++) begin
      code_chk(1'b1, 16'h0100, 17'h00100, 1'b0);
      op(K_DIR, 1'b1, 8'h84, {2'h0, 2'(b), 2'h0, 2'(3 - b)}, 16'h0);
      op(K_DIR, 1'b0, 8'h84, 8'h00, 16'h0);
      check(17'(rv), 17'({2'h0, 2'(b), 2'h0, 2'(3 - b)}));
      code_chk(1'b1, 16'h8abc, {2'(3 - b), 15'h0abc}, 1'b0);
      code_chk(1'b0, 16'hcabc, {2'(b), 15'h4abc}, 1'b0);
    end
    code_chk(1'b0, 16'h7fff, 17'h07fff, 1'b0);
    code_chk(1'b0, 16'hffff, 17'h1ffff, 1'b1);
    // upper-bank code may not move the fetch bank
    code_chk(1'b1, 16'h0100, 17'h00100, 1'b0);
    op(K_DIR, 1'b1, 8'h84, 8'h01, 16'h0);
    code_chk(1'b1, 16'h9000, 17'h09000, 1'b0);
    op(K_DIR, 1'b1, 8'h84, 8'h02, 16'h0);
    op(K_DIR, 1'b0, 8'h84, 8'h00, 16'h0);
    check(17'(rv), 17'h01);
    code_chk(1'b1, 16'h0100, 17'h00100, 1'b0);
    op(K_DIR, 1'b1, 8'h84, 8'h20, 16'h0);
    // upper ram versus special function space
    op(K_REG, 1'b1, 8'h00, 8'h90, 16'h0);
    op(K_IND, 1'b1, 8'h00, 8'h5a, 16'h0);
    busy_mark = busy_count;
    op(K_DIR, 1'b0, 8'h90, 8'h00, 16'h0);
    check(17'(rv), 17'h00);
    check(17'(busy_count - busy_mark), 17'h1);
    busy_mark = busy_count;
    op(K_IND, 1'b0, 8'h00, 8'h00, 16'h0);
    check(17'(rv), 17'h5a);
    check(17'(busy_count - busy_mark), 17'h2);
    op(K_DIR, 1'b1, 8'h30, 8'ha5, 16'h0);
    op(K_REG, 1'b1, 8'h01, 8'h30, 16'h0);
    op(K_IND, 1'b0, 8'h01, 8'h00, 16'h0);
    check(17'(rv), 17'ha5);
    // register banks
    for (int b = 0; b < 4; b++) begin
      op(K_DIR, 1'b1, 8'hd0, {3'h0, 2'(b), 3'h0}, 16'h0);
      op(K_REG, 1'b1, 8'(b + 2), 8'(8'h40 + b), 16'h0);
      op(K_DIR, 1'b0, 8'(9 * b + 2), 8'h00, 16'h0);
      check(17'(rv), 17'(8'h40 + b));
    end
    op(K_DIR, 1'b1, 8'hd0, 8'h00, 16'h0);
    // bit area
    op(K_DIR, 1'b1, 8'h22, 8'h00, 16'h0);
    op(K_BIT, 1'b1, 8'h13, 8'h01, 16'h0);
    op(K_DIR, 1'b0, 8'h22, 8'h00, 16'h0);
    check(17'(rv), 17'h08);
    op(K_BIT, 1'b0, 8'h13, 8'h00, 16'h0);
    check(17'(rv), 17'h01);
    op(K_DIR, 1'b1, 8'h2f, 8'h00, 16'h0);
    op(K_BIT, 1'b1, 8'h7f, 8'h01, 16'h0);
    op(K_DIR, 1'b0, 8'h2f, 8'h00, 16'h0);
    check(17'(rv), 17'h80);
    // stack
    op(K_PUSH, 1'b1, 8'h00, 8'h3c, 16'h0);
    op(K_DIR, 1'b0, 8'h08, 8'h00, 16'h0);
    check(17'(rv), 17'h3c);
    op(K_DIR, 1'b0, 8'h81, 8'h00, 16'h0);
    check(17'(rv), 17'h08);
    op(K_POP, 1'b0, 8'h00, 8'h00, 16'h0);
    check(17'(rv), 17'h3c);
    op(K_DIR, 1'b1, 8'h81, 8'hfe, 16'h0);
    op(K_PUSH, 1'b1, 8'h00, 8'h66, 16'h0);
    op(K_REG, 1'b1, 8'h00, 8'hff, 16'h0);
    op(K_IND, 1'b0, 8'h00, 8'h00, 16'h0);
    check(17'(rv), 17'h66);
    // external ram by pointer and by page plus index
    op(K_XDP, 1'b1, 8'h00, 8'hc3, 16'h1234);
    op(K_DIR, 1'b1, 8'haa, 8'h12, 16'h0);
    op(K_REG, 1'b1, 8'h01, 8'h34, 16'h0);
    op(K_XIX, 1'b0, 8'h01, 8'h00, 16'h0);
    check(17'(rv), 17'hc3);
    op(K_XDP, 1'b0, 8'h00, 8'h00, 16'h1234);
    check(17'(rv), 17'hc3);
    check(17'(prog_count), 17'h0);
    // routed flash write through constant bank 2
    i_core_access_model.set_route(1'b1);
    op(K_XDP, 1'b1, 8'h00, 8'h77, 16'h9000);
    op(K_XDP, 1'b0, 8'h00, 8'h00, 16'h1234);
    check(17'(rv), 17'hc3);
    i_core_access_model.set_route(1'b0);
    check(prog_addr, 17'h11000);
    check(17'(prog_wdata), 17'h77);
    check(17'(prog_count), 17'h1);
    stop_test();
  end
endmodule
`default_nettype wire
